/* core/ivp_pkg.sv */
// Purpose: Constants and types for the upper maskable interrupt vector and priority map
// Assumes: Sources 42 to 68 only; one CPU clock; synchronous active-high reset
// Notes:   Contract
// Contract
// - Among pending maskable requests, smallest default priority value wins; 0 highest.
// - Async channel 2 transmit enable: priority 46, code 0360H, handler 00000360H.
// - DMA channels 0-3 done: priorities 48-51, codes 0380H-03B0H.
// - Converter 47/0370H, key return 52/03C0H, watch interval 53/03D0H.
// - Watch reference time: priority 54, code 03E0H, handler 000003E0H.
// - External pin eight: priority 55, code 0470H; codes 03F0H-0460H unused.
// - Timer six overflow, ch0, ch1: priorities 56-58, codes 0480H-04A0H.
// - Timer seven 59-61 codes 04B0H-04D0H; timer eight 62-64 codes 04E0H-0500H.
// - Sync serial five receive 65/0510H, transmit write 66/0520H.
// - Async channel 3 receive 67/0530H, transmit 68/0540H; highest code 0540H.
// - Shared vectors: 43 at 0330H and 45 at 0350H each serve two sources.
// - On acceptance save restored PC into maskable, nonmaskable or debug save register.
// - Short load or divide interrupted: abort, save its own address to re-execute.
// - Prepare/dispose restart only when interrupted before stack pointer update.
// - Watchdog nonmaskable source wins over the nonmaskable pin when simultaneous.
// - Illegal opcode: saved value minus 4 equals faulting instruction address.
// - After accepting a maskable request, enter interrupts-disabled state.
// - Eight programmable priority levels per source, above default order.
// - On maskable acceptance write exception code to lower halfword of cause register.
package ivp_pkg;

  localparam int unsigned NUM_SRC   = 27;
  localparam int unsigned FIRST_PRI = 42;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned IDX_W     = 5;

  // Default priority 42 + i maps to code 0320H + 16*i for i 0-12; from i 13 on, 0470H + 16*(i-13) after the gap
  localparam logic [15:0] CODE_TBL [NUM_SRC] = '{
    16'h0320, 16'h0330, 16'h0340, 16'h0350, 16'h0360, 16'h0370, 16'h0380,
    16'h0390, 16'h03A0, 16'h03B0, 16'h03C0, 16'h03D0, 16'h03E0, 16'h0470,
    16'h0480, 16'h0490, 16'h04A0, 16'h04B0, 16'h04C0, 16'h04D0, 16'h04E0,
    16'h04F0, 16'h0500, 16'h0510, 16'h0520, 16'h0530, 16'h0540
  };

  localparam logic [15:0] CODE_NMI_PIN = 16'h0010;
  localparam logic [15:0] CODE_NMI_WDT = 16'h0020;
  localparam logic [15:0] CODE_ILLEGAL = 16'h0060;
  localparam logic [31:0] PC_STEP_ILL  = 32'h0000_0004;
  localparam logic [LVL_W-1:0] LVL_RST = 3'h7;
  localparam logic [31:0] PC_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    IVP_KIND_NONE,
    IVP_KIND_MASK,
    IVP_KIND_NMI,
    IVP_KIND_ILL
  } ivp_kind_t;

  typedef enum logic [1:0] {
    IVP_INS_PLAIN,
    IVP_INS_RESTART,
    IVP_INS_FRAME
  } ivp_ins_t;

endpackage

/* core/ivp_pick_if.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carries the arbitration result from the picker to the top
// Assumes: Same clock domain
// Notes:   Combinational result
interface ivp_pick_if;
  import ivp_pkg::*;
  logic                 hit;
  logic [IDX_W-1:0]     idx;
  logic [LVL_W-1:0]     lvl;
  modport picker (output hit, output idx, output lvl);
  modport user   (input hit, input idx, input lvl);
endinterface

/* core/ivp_pick.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Picks the winning maskable request by level then default order
// Assumes: Requests already masked and above the current service level
// Notes:   Lower index means higher default priority
module ivp_pick
  import ivp_pkg::*;
(
  // Requests and levels
  input  wire logic [NUM_SRC-1:0]       req,
  input  wire logic [NUM_SRC*LVL_W-1:0] lvls,
  // Result
  ivp_pick_if.picker                    res
);

  always_comb
  begin
    res.hit = 1'b0;
    res.idx = '0;
    res.lvl = '1;
    // Descending walk so smallest index wins among equal levels
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i] && (!res.hit || lvls[i*LVL_W +: LVL_W] <= res.lvl))
      begin
        res.hit = 1'b1;
        res.idx = IDX_W'(i);
        res.lvl = lvls[i*LVL_W +: LVL_W];
      end
    end
  end

endmodule

/* core/ivp_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: Maskable vectoring, nonmaskable ordering and restored PC selection
// Assumes: Requests are level, held by peripherals until accepted
// Notes:   One acceptance per cycle; nonmaskable before maskable
module ivp_top
  import ivp_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Maskable sources, index 0 is default priority 42
  input  wire logic [NUM_SRC-1:0]       irq_req,
  input  wire logic [NUM_SRC-1:0]       irq_mask,
  input  wire logic [NUM_SRC*LVL_W-1:0] irq_level,
  // Nonmaskable sources
  input  wire logic                     nmi_pin_req,
  input  wire logic                     watchdog_nmi_source,
  input  wire logic                     illegal_op,
  // CPU state
  input  wire logic [31:0]              cur_pc,
  input  wire logic [31:0]              following_instruction_address,
  input  wire ivp_ins_t                 cur_ins,
  input  wire logic                     sp_updated,
  input  wire logic                     debug_entry,
  input  wire logic                     enable_int,
  input  wire logic                     return_int,
  // Acceptance
  output logic                          take,
  output ivp_kind_t                     take_kind,
  output logic [IDX_W-1:0]              take_idx,
  output logic                          take_ack_pulse,
  output logic [31:0]                   handler_addr,
  output logic [31:0]                   maskable_saved_pc,
  output logic [31:0]                   nonmaskable_saved_pc,
  output logic [31:0]                   debug_saved_pc,
  output logic [15:0]                   maskable_cause_code,
  output logic [15:0]                   nonmaskable_cause_code,
  output logic                          int_disabled,
  output logic                          nmi_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration

  ivp_pick_if pick ();

  logic [NUM_SRC-1:0] eligible;
  logic [LVL_W-1:0]   svc_lvl_q;
  logic               svc_act_q;
  logic               di_q;
  logic               np_q;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_elig
      // Only strictly higher levels nest into an active service
      assign eligible[g] = irq_req[g] && !irq_mask[g] &&
                           (!svc_act_q || irq_level[g*LVL_W +: LVL_W] < svc_lvl_q);
    end
  endgenerate

  ivp_pick u_pick (
    .req  (eligible),
    .lvls (irq_level),
    .res  (pick)
  );

  logic nmi_go;
  logic wdt_win;
  logic mask_go;
  logic ill_go;

  assign wdt_win = watchdog_nmi_source;
  assign nmi_go  = (watchdog_nmi_source || nmi_pin_req) && !np_q;
  assign ill_go  = illegal_op && !nmi_go;
  assign mask_go = pick.hit && !di_q && !np_q && !nmi_go && !ill_go;

  //////////////////////////////////////////////////////////////////////////////
  // Restored PC choice

  logic        restart;
  logic [31:0] restored_pc;

  always_comb
  begin
    unique case (cur_ins)
      IVP_INS_RESTART: restart = 1'b1;
      IVP_INS_FRAME:   restart = !sp_updated;
      default:         restart = 1'b0;
    endcase
    restored_pc = restart ? cur_pc : following_instruction_address;
  end

  logic [15:0] win_code;
  assign win_code = CODE_TBL[pick.idx];

  //////////////////////////////////////////////////////////////////////////////
  // Acceptance outputs

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      take           <= 1'b0;
      take_kind      <= IVP_KIND_NONE;
      take_idx       <= '0;
      take_ack_pulse <= 1'b0;
      handler_addr   <= PC_RST;
    end
    else
    begin
      take           <= nmi_go || ill_go || mask_go;
      take_ack_pulse <= nmi_go || ill_go || mask_go;
      take_idx       <= pick.idx;
      if (nmi_go)
      begin
        take_kind    <= IVP_KIND_NMI;
        handler_addr <= {16'h0000, wdt_win ? CODE_NMI_WDT : CODE_NMI_PIN};
      end
      else if (ill_go)
      begin
        take_kind    <= IVP_KIND_ILL;
        handler_addr <= {16'h0000, CODE_ILLEGAL};
      end
      else if (mask_go)
      begin
        take_kind    <= IVP_KIND_MASK;
        handler_addr <= {16'h0000, win_code};
      end
      else
      begin
        take_kind    <= IVP_KIND_NONE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Save registers

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      maskable_saved_pc   <= PC_RST;
      maskable_cause_code <= '0;
    end
    else if (mask_go)
    begin
      maskable_saved_pc   <= restored_pc;
      maskable_cause_code <= win_code;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      nonmaskable_saved_pc   <= PC_RST;
      nonmaskable_cause_code <= '0;
    end
    else if (nmi_go)
    begin
      nonmaskable_saved_pc   <= restored_pc;
      nonmaskable_cause_code <= wdt_win ? CODE_NMI_WDT : CODE_NMI_PIN;
    end
    else if (ill_go)
    begin
      // Faulting address plus 4 so handler recovers it by subtracting 4
      nonmaskable_saved_pc   <= cur_pc + PC_STEP_ILL;
      nonmaskable_cause_code <= CODE_ILLEGAL;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      debug_saved_pc <= PC_RST;
    else if (debug_entry)
      debug_saved_pc <= restored_pc;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      di_q <= 1'b1;
    else if (mask_go || nmi_go || ill_go)
      di_q <= 1'b1;
    else if (enable_int)
      di_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      np_q <= 1'b0;
    else if (nmi_go)
      np_q <= 1'b1;
    else if (return_int)
      np_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      svc_act_q <= 1'b0;
      svc_lvl_q <= LVL_RST;
    end
    else if (mask_go)
    begin
      svc_act_q <= 1'b1;
      svc_lvl_q <= pick.lvl;
    end
    else if (return_int && !np_q)
    begin
      svc_act_q <= 1'b0;
      svc_lvl_q <= LVL_RST;
    end
  end

  assign int_disabled = di_q;
  assign nmi_busy     = np_q;

endmodule

/* tb/ivp_asserts.sv */
// Purpose: Port assertions for ivp_top
// Assumes: One clock, synchronous reset
// Notes:   Bound from the bench top
module ivp_asserts
  import ivp_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             sys_rst,
  // Sources and CPU state
  input wire logic             nmi_pin_req,
  input wire logic             watchdog_nmi_source,
  input wire logic             illegal_op,
  input wire logic [31:0]      cur_pc,
  input wire logic [31:0]      following_instruction_address,
  input wire ivp_ins_t         cur_ins,
  input wire logic             sp_updated,
  // Acceptance
  input wire logic             take,
  input wire ivp_kind_t        take_kind,
  input wire logic [IDX_W-1:0] take_idx,
  input wire logic             take_ack_pulse,
  input wire logic [31:0]      handler_addr,
  input wire logic [31:0]      maskable_saved_pc,
  input wire logic [31:0]      nonmaskable_saved_pc,
  input wire logic [15:0]      maskable_cause_code,
  input wire logic [15:0]      nonmaskable_cause_code,
  input wire logic             int_disabled,
  input wire logic             nmi_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  wire logic mk = take && take_kind == IVP_KIND_MASK;

  a_ack_mirrors_take: assert property (take_ack_pulse == take
    && take == (take_kind != IVP_KIND_NONE)) else $error("ack or kind differs from take");
  a_accept_disables: assert property (mk |-> int_disabled)
    else $error("maskable accept left enabled");
  a_disabled_blocks: assert property (int_disabled |=> !mk)
    else $error("maskable taken while disabled");
  a_handler_zext: assert property (mk |-> handler_addr == {16'h0000, maskable_cause_code})
    else $error("handler not code extended");
  a_code_map: assert property (mk |-> maskable_cause_code == CODE_TBL[take_idx])
    else $error("code does not match source");
  a_wdt_wins: assert property (watchdog_nmi_source && !nmi_busy
    |=> take && nonmaskable_cause_code == 16'h0020) else $error("watchdog not first");
  a_restart_pc: assert property (mk && $past(cur_ins) == IVP_INS_RESTART
    |-> maskable_saved_pc == $past(cur_pc)) else $error("restart pc wrong");
  a_frame_late: assert property (mk && $past(cur_ins) == IVP_INS_FRAME && $past(sp_updated)
    |-> maskable_saved_pc == $past(following_instruction_address)) else $error("frame pc wrong");
  a_illegal_pc: assert property (illegal_op && !((watchdog_nmi_source || nmi_pin_req)
    && !nmi_busy) |=> take_kind == IVP_KIND_ILL && nonmaskable_saved_pc == $past(cur_pc) + 32'h0000_0004)
    else $error("illegal pc wrong");
endmodule

/* tb/ivp_src_model.sv */
// Purpose: Peripheral sources holding requests until acknowledged
// Assumes: Raise pulses come from the bench
// Notes:   Clears only the accepted source
module ivp_src_model
  import ivp_pkg::*;
(
  // Clock and reset
  input wire logic               clock,
  input wire logic               sys_rst,
  // Raise pulses and acceptance
  input wire logic [NUM_SRC-1:0] raise,
  input wire logic               take,
  input wire ivp_kind_t          take_kind,
  input wire logic [IDX_W-1:0]   take_idx,
  // Held levels
  output logic [NUM_SRC-1:0]     irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq_req <= '0;
    else if (take && take_kind == IVP_KIND_MASK)
      irq_req <= (irq_req | raise) & ~((NUM_SRC)'(1) << take_idx);
    else
      irq_req <= irq_req | raise;
  end
endmodule

/* tb/tb_interrupt_vector_priority_map.sv */
// Purpose: Self-checking bench for ivp_top
// Assumes: Inputs change on falling edges
// Notes:   Sources held by the partner model
module tb_interrupt_vector_priority_map
  import ivp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, sys_rst = 1, nmi_pin_req = 0, watchdog_nmi_source = 0, illegal_op = 0;
  logic sp_updated = 0, debug_entry = 0, enable_int = 0, return_int = 0;
  logic [NUM_SRC-1:0] raise = '0, irq_req, irq_mask = '0;
  logic [NUM_SRC*LVL_W-1:0] irq_level = '1;
  logic [31:0] cur_pc = 32'h0000_1000, following_instruction_address = 32'h0000_2000;
  ivp_ins_t cur_ins = IVP_INS_PLAIN;
  logic take, take_ack_pulse, int_disabled, nmi_busy;
  ivp_kind_t take_kind;
  logic [IDX_W-1:0] take_idx;
  logic [31:0] handler_addr, maskable_saved_pc, nonmaskable_saved_pc, debug_saved_pc;
  logic [15:0] maskable_cause_code, nonmaskable_cause_code;
  int num_errors = 0, n_checks = 0;
  ivp_top dut_u (.*);
  ivp_src_model src_u (.*);
  always #12.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  function automatic logic [15:0] code_of(input int i);
    return (i < 13) ? 16'h0320 + 16'(i * 16) : 16'h0470 + 16'(i * 16 - 208);
  endfunction
  task automatic pulse_ret();
    return_int = 1;
    @(negedge clock) return_int = 0;
  endtask
  task automatic wait_take();
    int n = 0;
    while (take !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    chk({31'h0, take}, 1, "take");
  endtask
  task automatic serve(input int i);
    enable_int = 1;
    @(negedge clock) enable_int = 0;
    wait_take();
    chk(32'(take_idx), 32'(i), "source");
    chk(32'(take_kind), 32'(IVP_KIND_MASK), "kind");
    chk({16'h0, maskable_cause_code}, {16'h0, code_of(i)}, "code");
    chk(handler_addr, {16'h0, code_of(i)}, "handler");
    chk({31'h0, int_disabled}, 1, "disabled");
    pulse_ret();
  endtask
  task automatic up(input logic [NUM_SRC-1:0] v);
    raise = v;
    @(negedge clock) raise = '0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clock);
    sys_rst = 0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      up((NUM_SRC)'(1) << i);
      serve(i);
    end
    irq_mask[5] = 1;
    up(27'h400_2020);
    serve(13);
    irq_mask[5] = 0;
    serve(5);
    serve(26);
    irq_level[78 +: 3] = 3'h0;
    up(27'h400_0001);
    serve(26);
    serve(0);
    for (int k = 0; k < 4; k++)
    begin
      cur_ins = k == 0 ? IVP_INS_PLAIN : (k == 1 ? IVP_INS_RESTART : IVP_INS_FRAME);
      sp_updated = k == 3;
      up(27'h2);
      serve(1);
      chk(maskable_saved_pc, (k == 0 || k == 3) ? 32'h0000_2000 : 32'h0000_1000, "saved");
    end
    cur_ins = IVP_INS_PLAIN;
    watchdog_nmi_source = 1;
    nmi_pin_req = 1;
    up(27'h4);
    watchdog_nmi_source = 0;
    wait_take();
    chk({16'h0, nonmaskable_cause_code}, 32'h0000_0020, "nmi code");
    chk({31'h0, nmi_busy}, 1, "nmi busy");
    enable_int = 1;
    @(negedge clock) enable_int = 0;
    repeat (5) @(negedge clock) chk({31'h0, take}, 0, "refused");
    pulse_ret();
    wait_take();
    nmi_pin_req = 0;
    chk({16'h0, nonmaskable_cause_code}, 32'h0000_0010, "pin code");
    pulse_ret();
    serve(2);
    illegal_op = 1;
    cur_pc = 32'h0000_3000;
    @(negedge clock) illegal_op = 0;
    wait_take();
    chk(nonmaskable_saved_pc, 32'h0000_3004, "illegal pc");
    debug_entry = 1;
    @(negedge clock) debug_entry = 0;
    @(negedge clock);
    chk(debug_saved_pc, 32'h0000_2000, "debug pc");
    end_of_test();
  end
  initial
  begin
    repeat (4000) @(posedge clock);
    num_errors++;
    end_of_test();
  end
endmodule
bind ivp_top ivp_asserts chk_u (.*);
